// ---- design/cse_consts.svh ----
// Register offsets, field positions, reset values and sizes of the
// console status export block.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef CSE_CONSTS_SVH
`define CSE_CONSTS_SVH

// ****************************************************************
// Line group sizes
// ****************************************************************
`define CSE_ROWS 4
`define CSE_ROW_BITS 28
`define CSE_ALPHA_LINES 3
`define CSE_NUMERIC_LINES 7
`define CSE_UNITS 28
`define CSE_SENSE_BITS 8
`define CSE_IND_BITS 8

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CSE_OFF_ROW0 12'h000
`define CSE_OFF_ROW1 12'h004
`define CSE_OFF_ROW2 12'h008
`define CSE_OFF_ROW3 12'h00C
`define CSE_OFF_MODE 12'h010
`define CSE_OFF_PWR 12'h014
`define CSE_OFF_ISTAT 12'h018
`define CSE_OFF_IMASK 12'h01C
`define CSE_OFF_SENSE 12'h020
`define CSE_OFF_IND 12'h024

// ****************************************************************
// Mode register fields and register reset values
// ****************************************************************
`define CSE_MODE_ALPHA_LSB 0
`define CSE_MODE_NUM_LSB 4
`define CSE_ALPHA_RESET 3'h1
`define CSE_NUMERIC_RESET 7'h01
`define CSE_ROW_RESET 28'h0000000
`define CSE_IND_RESET 8'h00

`endif

// ---- design/cse_pkg.sv ----
// Types shared by the console status export design.
// Assumes cse_consts.svh is on the include path.
`include "cse_consts.svh"

package cse_pkg;
   typedef logic [`CSE_ROW_BITS-1:0] cse_row_t;
   typedef logic [`CSE_UNITS-1:0] cse_units_t;
   typedef logic [`CSE_ALPHA_LINES-1:0] cse_alpha_t;
   typedef logic [`CSE_NUMERIC_LINES-1:0] cse_numeric_t;
endpackage

// ---- design/cse_sync.sv ----
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow static level from outside the mclk domain.
`timescale 1ns/10ps

module cse_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Levels
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_q <= '0;
         syncOut <= '0;
      end else begin
         stage1_q <= asyncIn;
         syncOut <= stage1_q;
      end
   end
endmodule

// ---- design/console_status_export.sv ----
// Console status export: lamp rows, mode indicator and power-check
// lines toward the maintenance monitor console, mirrored on the panel.
// Assumes an APB master on mclk and unit condition pins from outside.
//
// How it works
// - Drive four 28-line configuration lamp rows.
// - Every row line always has a defined value.
// - Mode indicator: three alpha, seven numeric lines.
// - Exactly one alpha, one numeric line active.
// - Twenty-eight power-check lines, one per unit.
// - Power check on off, overtemperature, supply failure.
// - Exported lines equal the panel display.
// - Program reaches switches, indicators over I/O bus.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`include "cse_consts.svh"

module console_status_export
   import cse_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Unit condition pins
   input wire logic [`CSE_UNITS-1:0] unitPowerOff,
   input wire logic [`CSE_UNITS-1:0] unitOverTemp,
   input wire logic [`CSE_UNITS-1:0] unitSupplyFail,
   // Console sense switches and program indicators
   input wire logic [`CSE_SENSE_BITS-1:0] senseSwitch,
   output logic [`CSE_IND_BITS-1:0] progIndicator,
   // Lines toward the maintenance monitor console
   output logic [`CSE_ROWS*`CSE_ROW_BITS-1:0] monConfigLamp,
   output logic [`CSE_ALPHA_LINES-1:0] monModeAlpha,
   output logic [`CSE_NUMERIC_LINES-1:0] monModeNumeric,
   output logic [`CSE_UNITS-1:0] monPowerCheck,
   // Operator panel display
   output logic [`CSE_ROWS*`CSE_ROW_BITS-1:0] panelConfigLamp,
   output logic [`CSE_ALPHA_LINES-1:0] panelModeAlpha,
   output logic [`CSE_NUMERIC_LINES-1:0] panelModeNumeric,
   output logic [`CSE_UNITS-1:0] panelPowerCheck
);

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************
   // One-hot of a field index; zero when the index is out of range
   function automatic logic [7:0] oneHot(input logic [2:0] idx,
                                          input logic [3:0] lines);
      logic [7:0] r;
      r = 8'h00;
      if ({1'b0, idx} < lines) begin
         r[idx] = 1'b1;
      end
      return r;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [3*`CSE_UNITS+`CSE_SENSE_BITS-1:0] pinSync;

   cse_sync #(
      .WIDTH(3*`CSE_UNITS+`CSE_SENSE_BITS)
   ) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .asyncIn({senseSwitch, unitSupplyFail, unitOverTemp, unitPowerOff}),
      .syncOut(pinSync)
   );

   wire cse_units_t offSync = pinSync[`CSE_UNITS-1:0];
   wire cse_units_t hotSync = pinSync[2*`CSE_UNITS-1:`CSE_UNITS];
   wire cse_units_t failSync = pinSync[3*`CSE_UNITS-1:2*`CSE_UNITS];
   wire logic [`CSE_SENSE_BITS-1:0] senseSync =
      pinSync[3*`CSE_UNITS+`CSE_SENSE_BITS-1:3*`CSE_UNITS];

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire logic setup = psel & ~penable;
   wire logic wrStb = psel & penable & pwrite;
   wire logic hitRow0 = paddr == `CSE_OFF_ROW0;
   wire logic hitRow1 = paddr == `CSE_OFF_ROW1;
   wire logic hitRow2 = paddr == `CSE_OFF_ROW2;
   wire logic hitRow3 = paddr == `CSE_OFF_ROW3;
   wire logic hitMode = paddr == `CSE_OFF_MODE;
   wire logic hitPwr = paddr == `CSE_OFF_PWR;
   wire logic hitIstat = paddr == `CSE_OFF_ISTAT;
   wire logic hitImask = paddr == `CSE_OFF_IMASK;
   wire logic hitSense = paddr == `CSE_OFF_SENSE;
   wire logic hitInd = paddr == `CSE_OFF_IND;
   wire logic [3:0] hitRow = {hitRow3, hitRow2, hitRow1, hitRow0};
   wire logic mapped = (|hitRow) | hitMode | hitPwr | hitIstat
      | hitImask | hitSense | hitInd;

   // ****************************************************************
   // Configuration lamp rows
   // ****************************************************************
   cse_row_t cfgRow_q [`CSE_ROWS];

   genvar g;
   generate
      for (g = 0; g < `CSE_ROWS; g++) begin : g_row
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               cfgRow_q[g] <= `CSE_ROW_RESET;
            end else if (wrStb && hitRow[g]) begin
               cfgRow_q[g] <= pwdata[`CSE_ROW_BITS-1:0];
            end
         end
         assign monConfigLamp[g*`CSE_ROW_BITS +: `CSE_ROW_BITS] =
            cfgRow_q[g];
      end
   endgenerate

   // ****************************************************************
   // Mode indicator
   // ****************************************************************
   cse_alpha_t alpha_q;
   cse_numeric_t numeric_q;
   wire logic [2:0] alphaIdx = pwdata[`CSE_MODE_ALPHA_LSB +: 3];
   wire logic [2:0] numIdx = pwdata[`CSE_MODE_NUM_LSB +: 3];
   wire logic [7:0] alphaHot = oneHot(alphaIdx, 4'h3);
   wire logic [7:0] numHot = oneHot(numIdx, 4'h7);
   wire logic modeOk = (|alphaHot) & (|numHot);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         alpha_q <= `CSE_ALPHA_RESET;
         numeric_q <= `CSE_NUMERIC_RESET;
      end else if (wrStb && hitMode && modeOk) begin
         alpha_q <= alphaHot[`CSE_ALPHA_LINES-1:0];
         numeric_q <= numHot[`CSE_NUMERIC_LINES-1:0];
      end
   end

   // Index read back of the one-hot groups
   function automatic logic [2:0] hotIdx(input logic [7:0] hot);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (hot[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   wire logic [2:0] alphaRd = hotIdx({5'h00, alpha_q});
   wire logic [2:0] numRd = hotIdx({1'b0, numeric_q});

   // ****************************************************************
   // Power check lines
   // ****************************************************************
   cse_units_t pwrChk_q;
   wire cse_units_t pwrChkD = offSync | hotSync | failSync;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pwrChk_q <= '0;
      end else begin
         pwrChk_q <= pwrChkD;
      end
   end

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   cse_units_t istat_q;
   cse_units_t istat_d;
   cse_units_t imask_q;
   wire cse_units_t pwrRise = pwrChkD & ~pwrChk_q;
   wire cse_units_t w1c = (wrStb && hitIstat) ?
      pwdata[`CSE_UNITS-1:0] : '0;

   // Set wins over a clear in the same cycle
   assign istat_d = (istat_q & ~w1c) | pwrRise;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         istat_q <= '0;
         imask_q <= '0;
      end else begin
         istat_q <= istat_d;
         if (wrStb && hitImask) begin
            imask_q <= pwdata[`CSE_UNITS-1:0];
         end
      end
   end

   assign irq = |(istat_q & imask_q);

   // ****************************************************************
   // Program indicators
   // ****************************************************************
   // Program-addressable indicators
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         progIndicator <= `CSE_IND_RESET;
      end else if (wrStb && hitInd) begin
         progIndicator <= pwdata[`CSE_IND_BITS-1:0];
      end
   end

   // ****************************************************************
   // Read data and answer
   // ****************************************************************
   // Sense switches readable
   wire logic [31:0] rdMux =
      hitRow0 ? {4'h0, cfgRow_q[0]} :
      hitRow1 ? {4'h0, cfgRow_q[1]} :
      hitRow2 ? {4'h0, cfgRow_q[2]} :
      hitRow3 ? {4'h0, cfgRow_q[3]} :
      hitMode ? {25'h0000000, numRd, 1'b0, alphaRd} :
      hitPwr ? {4'h0, pwrChk_q} :
      hitIstat ? {4'h0, istat_q} :
      hitImask ? {4'h0, imask_q} :
      hitSense ? {24'h000000, senseSync} :
      hitInd ? {24'h000000, progIndicator} : 32'h00000000;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : rdMux;
         pslverr <= ~mapped;
      end
   end

   assign pready = 1'b1;

   // ****************************************************************
   // Exported and panel lines
   // ****************************************************************
   assign monModeAlpha = alpha_q;
   assign monModeNumeric = numeric_q;
   assign monPowerCheck = pwrChk_q;
   assign panelConfigLamp = monConfigLamp;
   assign panelModeAlpha = alpha_q;
   assign panelModeNumeric = numeric_q;
   assign panelPowerCheck = pwrChk_q;

endmodule

// ---- verif/cse_monitor_model.sv ----
// Maintenance monitor model: samples the exported lamp levels.
// Assumes the lines are static levels clocked by mclk.
`timescale 1ns/10ps
module cse_monitor_model #(
   parameter logic [27:0] FITTED = 28'h0FFFFFF
) (
   // Clock
   input wire logic mclk,
   // Received and seen lamps
   input wire logic [111:0] lamp,
   output logic [111:0] seenLamp
);
   always_ff @(posedge mclk) begin
      seenLamp <= lamp & {4{FITTED}};
   end
endmodule

// ---- verif/cse_export_asserts.sv ----
// Port checker for the console status export block.
// Assumes one mclk domain; bound to the block below.
`timescale 1ns/10ps
module cse_checker (
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic irq,
   // Unit conditions
   input wire logic [27:0] unitPowerOff,
   input wire logic [27:0] unitOverTemp,
   input wire logic [27:0] unitSupplyFail,
   // Exported and panel lines
   input wire logic [111:0] monConfigLamp,
   input wire logic [2:0] monModeAlpha,
   input wire logic [6:0] monModeNumeric,
   input wire logic [27:0] monPowerCheck,
   input wire logic [111:0] panelConfigLamp,
   input wire logic [2:0] panelModeAlpha,
   input wire logic [6:0] panelModeNumeric,
   input wire logic [27:0] panelPowerCheck
);
   logic [1:0] rstAge_q;
   wire logic [27:0] anyCond = unitPowerOff | unitOverTemp | unitSupplyFail;
   wire logic wrAccess = psel && penable && pwrite;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rstAge_q <= 2'h0;
      end else if (rstAge_q != 2'h3) begin
         rstAge_q <= rstAge_q + 2'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence lineMoved;
      !$stable(monConfigLamp) || !$stable(monModeAlpha)
         || !$stable(monModeNumeric);
   endsequence
   sequence mappedAccess;
      psel && penable && paddr <= 12'h024 && paddr[1:0] == 2'h0;
   endsequence
   chk_mode_onehot: assert property (
      $onehot(monModeAlpha) && $onehot(monModeNumeric))
      else $error("mode lines not one-hot");
   chk_panel_same: assert property (
      monConfigLamp == panelConfigLamp && monPowerCheck == panelPowerCheck
      && monModeAlpha == panelModeAlpha && monModeNumeric == panelModeNumeric)
      else $error("panel differs from monitor lines");
   chk_pwr_follow: assert property (
      rstAge_q == 2'h3 |-> monPowerCheck == $past(anyCond, 3))
      else $error("power check does not follow conditions");
   chk_lines_static: assert property (
      lineMoved |-> $past(wrAccess))
      else $error("lines moved without a write");
   chk_err_unmapped: assert property (
      psel && penable && paddr > 12'h024 |-> pslverr)
      else $error("unmapped access without error");
   chk_err_mapped: assert property (
      mappedAccess |-> !pslverr)
      else $error("mapped access flagged as error");
   chk_irq_cause: assert property (
      $rose(irq) |-> monPowerCheck != 28'h0 || $past(wrAccess))
      else $error("interrupt without cause");
   chk_pwr_rise: assert property (
      $rose(monPowerCheck[27]) |-> $past(anyCond[27], 3))
      else $error("last unit power check without cause");
endmodule
bind console_status_export cse_checker chk (
   .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .irq(irq),
   .unitPowerOff(unitPowerOff), .unitOverTemp(unitOverTemp),
   .unitSupplyFail(unitSupplyFail), .monConfigLamp(monConfigLamp),
   .monModeAlpha(monModeAlpha), .monModeNumeric(monModeNumeric),
   .monPowerCheck(monPowerCheck), .panelConfigLamp(panelConfigLamp),
   .panelModeAlpha(panelModeAlpha), .panelModeNumeric(panelModeNumeric),
   .panelPowerCheck(panelPowerCheck));

// ---- verif/console_status_export_bench.sv ----
// Self-checking bench for the console status export block.
// Assumes the design files and constants header on the include path.
`timescale 1ns/10ps
`include "cse_consts.svh"
module console_status_export_bench;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [27:0] unitPowerOff, unitOverTemp, unitSupplyFail, monPowerCheck;
   logic [27:0] panelPowerCheck;
   logic [111:0] monConfigLamp, panelConfigLamp, seenLamp;
   logic [2:0] monModeAlpha, panelModeAlpha;
   logic [6:0] monModeNumeric, panelModeNumeric;
   logic [7:0] senseSwitch, progIndicator;
   int failures = 0;
   int comparisons = 0;
   console_status_export dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .unitPowerOff(unitPowerOff), .unitOverTemp(unitOverTemp),
      .unitSupplyFail(unitSupplyFail), .senseSwitch(senseSwitch),
      .progIndicator(progIndicator), .monConfigLamp(monConfigLamp),
      .monModeAlpha(monModeAlpha), .monModeNumeric(monModeNumeric),
      .monPowerCheck(monPowerCheck), .panelConfigLamp(panelConfigLamp),
      .panelModeAlpha(panelModeAlpha), .panelModeNumeric(panelModeNumeric),
      .panelPowerCheck(panelPowerCheck));
   cse_monitor_model mon (.mclk(mclk), .lamp(monConfigLamp),
      .seenLamp(seenLamp));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic end_sim();
      $display("compares %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
      int n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic t_lamps();
      logic [31:0] v;
      chk(32'(monConfigLamp[111:84]), 32'h0);
      chk(32'(monModeAlpha), 32'h1);
      rdc(`CSE_OFF_MODE, 32'h0);
      for (int r = 0; r < 4; r++)
         apb(1'b1, 12'(4 * r), {4'hF, 28'h5A5A5A5 ^ 28'(r)});
      @(posedge mclk);
      for (int r = 0; r < 4; r++) begin
         v = {4'h0, 28'h5A5A5A5 ^ 28'(r)};
         chk(32'(monConfigLamp[28*r +: 28]), v);
         chk(32'(panelConfigLamp[28*r +: 28]), v);
         rdc(12'(4 * r), v);
      end
      chk(32'(seenLamp[111:84]), 32'h00A5A5A6);
      $display("test lamps done");
   endtask
   task automatic t_mode();
      for (int a = 0; a < 3; a++)
         for (int n = 0; n < 7; n++) begin
            apb(1'b1, `CSE_OFF_MODE, 32'(n * 16 + a));
            @(posedge mclk);
            chk(32'(monModeAlpha), 32'h1 << a);
            chk(32'(monModeNumeric), 32'h1 << n);
         end
      apb(1'b1, `CSE_OFF_MODE, 32'h73);
      rdc(`CSE_OFF_MODE, 32'h62);
      chk(32'(panelModeNumeric), 32'h40);
      $display("test mode done");
   endtask
   task automatic t_power();
      apb(1'b1, `CSE_OFF_IMASK, 32'h0FFFFFFF);
      for (int g = 0; g < 3; g++)
         for (int i = 0; i < 28; i += 27) begin
            {unitSupplyFail, unitOverTemp, unitPowerOff} <= 84'h1 << (28*g+i);
            repeat (4) @(posedge mclk);
            chk(32'(monPowerCheck), 32'h1 << i);
            chk(32'(panelPowerCheck), 32'h1 << i);
            chk(32'(irq), 32'h1);
            rdc(`CSE_OFF_PWR, 32'h1 << i);
            {unitSupplyFail, unitOverTemp, unitPowerOff} <= 84'h0;
            repeat (4) @(posedge mclk);
            apb(1'b1, `CSE_OFF_ISTAT, 32'h0FFFFFFF);
            @(posedge mclk);
            chk(32'(irq), 32'h0);
         end
      apb(1'b1, `CSE_OFF_IMASK, 32'h0);
      unitOverTemp <= 28'h10;
      repeat (4) @(posedge mclk);
      chk(32'(irq), 32'h0);
      rdc(`CSE_OFF_ISTAT, 32'h10);
      apb(1'b1, `CSE_OFF_IMASK, 32'h10);
      @(posedge mclk);
      chk(32'(irq), 32'h1);
      rdc(`CSE_OFF_IMASK, 32'h10);
      $display("test power done");
   endtask
   task automatic t_io();
      senseSwitch <= 8'h3C;
      apb(1'b1, `CSE_OFF_IND, 32'hA5);
      apb(1'b1, `CSE_OFF_SENSE, 32'hFF);
      @(posedge mclk);
      chk(32'(progIndicator), 32'hA5);
      chk(32'(pready), 32'h1);
      rdc(`CSE_OFF_IND, 32'hA5);
      rdc(`CSE_OFF_SENSE, 32'h3C);
      rdc(12'h040, 32'h0);
      chk(32'(err), 32'h1);
      $display("test io done");
   endtask
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {unitSupplyFail, unitOverTemp, unitPowerOff} = 84'h0;
      senseSwitch = 8'h00;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      t_lamps();
      t_mode();
      t_power();
      t_io();
      end_sim();
   end
endmodule
